// *** core/dsw_packer.sv ***
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
module dsw_packer
	import dsw_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	input  wire logic              ce,
	input  wire logic              force_valid,
	input  wire logic signed [7:0] open_force_deviation,
	input  wire logic        [1:0] obstruction_flags,
	input  wire logic              obstruction_response_active,
	input  wire logic        [6:0] status_display_code,
	input  wire logic        [4:0] gen_inputs,
	input  wire logic        [1:0] safety_inputs,
	input  wire logic        [1:0] safety_input_errors,
	input  wire logic        [1:0] safety_freq_inputs,
	input  wire logic        [1:0] safety_freq_input_errors,
	input  wire logic        [1:0] relay_outputs,
	input  wire logic        [6:0] ctrl_load_percent,
	input  wire logic        [6:0] motor_load_percent,
	input  wire logic              position_valid,
	input  wire logic        [6:0] door_position_percent,
	input  wire logic        [4:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic       [31:0] avs_writedata,
	input  wire logic        [3:0] avs_byteenable,
	output logic            [31:0] avs_readdata,
	output logic                   avs_waitrequest,
	output logic                   irq,
	output logic            [15:0] tech_status_word_one,
	output logic            [15:0] tech_status_word_two,
	output logic            [15:0] tech_status_word_three
);
	typedef struct packed {
		logic [15:0]         w1;
		logic [15:0]         w2;
		logic [15:0]         w3;
		logic [DSW_EV_N-1:0] sts;
		logic [DSW_EV_N-1:0] mask;
		logic [DSW_EV_N-1:0] ev_prev;
		logic [DSW_EV_N-1:0] rd_snap;
		logic                ack;
		logic [31:0]         rdata;
		logic                irq;
		logic                run;
	} dsw_core_state_t;

	dsw_core_state_t st_reg;
	dsw_core_state_t st_next;

	logic [1:0]          rst_sync_reg;
	logic                rst_n_s;
	logic [10:0]         pins_raw;
	logic [10:0]         pins_s;
	logic [4:0]          din_s;
	logic [1:0]          safety_inputs_s;
	logic [1:0]          safety_freq_inputs_s;
	logic [1:0]          relay_s;
	logic [2:0]          force_code;
	logic [6:0]          load_max;
	logic [6:0]          pos_field;
	logic [DSW_EV_N-1:0] ev_level;
	logic [DSW_EV_N-1:0] ev_rise;
	logic                req;
	logic                done;
	logic [DSW_EV_N-1:0] wdata_lo;

	// Reset asserts at once, releases two enabled (ce high) edges later
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			rst_sync_reg <= 2'h0;
		else if (ce)
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n_s = rst_sync_reg[1];

	// Pin levels only; internal flags share this clock
	assign pins_raw = {relay_outputs, safety_freq_inputs,
		safety_inputs, gen_inputs};

	dsw_sync #(
		.W (11)
	) u_pin_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n_s),
		.ce      (ce),
		.d       (pins_raw),
		.q       (pins_s)
	);

	assign din_s   = pins_s[4:0];
	assign safety_inputs_s  = pins_s[6:5];
	assign safety_freq_inputs_s  = pins_s[8:7];
	assign relay_s = pins_s[10:9];

	dsw_band_enc u_band (
		.valid   (force_valid),
		.dev_pct (open_force_deviation),
		.code    (force_code)
	);

	// larger of the two loads wins
	assign load_max = (ctrl_load_percent >= motor_load_percent) ?
		ctrl_load_percent : motor_load_percent;

	assign pos_field = position_valid ? door_position_percent :
		DSW_POS_NONE;

	assign ev_level = {|safety_freq_input_errors, |safety_input_errors,
		obstruction_response_active, obstruction_flags};
	assign ev_rise = ev_level & ~st_reg.ev_prev;

	// Two-cycle access: readdata is registered before release
	assign req  = avs_read | avs_write;
	// A frozen cycle must not answer the master
	assign done = req & st_reg.ack & ce;
	assign avs_waitrequest = req & ~(st_reg.ack & ce);

	always_comb begin
		st_next = st_reg;
		if (ce) begin
			st_next.w1 = DSW_WORD_RST;
			st_next.w1[DSW_W1_FORCE +: 3] = force_code;
			st_next.w1[DSW_W1_OBST] = obstruction_flags[0];
			st_next.w1[DSW_W1_OBST + 1] = obstruction_flags[1];
			st_next.w1[DSW_W1_RESP] = obstruction_response_active;
			st_next.w1[DSW_W1_CODE +: 7] = status_display_code;

			st_next.w2 = DSW_WORD_RST;
			st_next.w2[DSW_W2_DIN +: 5] = din_s;
			st_next.w2[DSW_W2_SAFETY_INPUTS +: 2] = safety_inputs_s;
			st_next.w2[DSW_W2_SDERR +: 2] = safety_input_errors;
			st_next.w2[DSW_W2_SAFETY_FREQ_INPUTS +: 2] = safety_freq_inputs_s;
			st_next.w2[DSW_W2_SFERR +: 2] = safety_freq_input_errors;
			st_next.w2[DSW_W2_RELAY +: 2] = relay_s;

			st_next.w3 = DSW_WORD_RST;
			st_next.w3[DSW_W3_LOAD +: 7] = load_max;
			st_next.w3[DSW_W3_POS +: 7] = pos_field;

			st_next.ev_prev = ev_level;
			st_next.ack = req & ~st_reg.ack;
			st_next.run = 1'b1;

			// Read data captured one edge before the master takes it
			if (avs_read && !st_reg.ack) begin
				st_next.rdata = 32'h0000_0000;
				case (avs_address)
					DSW_OFS_WORD1: st_next.rdata[15:0] = st_reg.w1;
					DSW_OFS_WORD2: st_next.rdata[15:0] = st_reg.w2;
					DSW_OFS_WORD3: st_next.rdata[15:0] = st_reg.w3;
					DSW_OFS_STAT: begin
						st_next.rdata[DSW_EV_N-1:0] = st_reg.sts;
					end
					DSW_OFS_MASK: begin
						st_next.rdata[DSW_EV_N-1:0] = st_reg.mask;
					end
					default: st_next.rdata = 32'h0000_0000;
				endcase
				st_next.rd_snap = st_reg.sts;
			end

			// Clear only bits the read reported; new events survive
			st_next.sts = st_reg.sts;
			if (done && avs_read && avs_address == DSW_OFS_STAT)
				st_next.sts = st_reg.sts & ~st_reg.rd_snap;
			st_next.sts = st_next.sts | ev_rise;

			if (done && avs_write && avs_address == DSW_OFS_MASK &&
				avs_byteenable[0])
				st_next.mask = avs_writedata[DSW_EV_N-1:0];

			st_next.irq = |(st_next.sts & st_next.mask);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_s) begin
		if (!rst_n_s)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign avs_readdata           = st_reg.rdata;
	assign irq                    = st_reg.irq;
	assign tech_status_word_one   = st_reg.w1;
	assign tech_status_word_two   = st_reg.w2;
	assign tech_status_word_three = st_reg.w3;
	assign wdata_lo               = avs_writedata[DSW_EV_N-1:0];

	default clocking dsw_cb @(posedge sys_clk);
	endclocking
	// Checks wait for the first enabled edge after release
	default disable iff (!st_reg.run);

	sequence rd_req_s;
		ce && avs_read && avs_waitrequest;
	endsequence

	sequence rd_hold_s;
		ce && avs_read;
	endsequence

	sequence mask_wr_s;
		ce && avs_write && st_reg.ack && avs_address == DSW_OFS_MASK &&
		avs_byteenable[0];
	endsequence

	sequence stat_rd_s;
		ce && avs_read && st_reg.ack && avs_address == DSW_OFS_STAT &&
		ev_rise == DSW_EV_RST;
	endsequence

	force_none_a: assert property (
		ce && !force_valid |=> tech_status_word_one[5:3] == 3'h0)
		else $error("force band not zero when unavailable");

	force_band_a: assert property (
		ce && force_valid && open_force_deviation >= DSW_DEV_P75
		|=> tech_status_word_one[5:3] == 3'h7)
		else $error("force band wrong for large deviation");

	obst_open_a: assert property (
		ce |=> tech_status_word_one[6] == $past(obstruction_flags[0]))
		else $error("opening obstruction bit wrong");

	obst_close_a: assert property (
		ce |=> tech_status_word_one[7] == $past(obstruction_flags[1]))
		else $error("closing obstruction bit wrong");

	resp_flag_a: assert property (
		ce |=> tech_status_word_one[8] ==
		$past(obstruction_response_active))
		else $error("response flag wrong");

	stat_code_a: assert property (
		ce |=> tech_status_word_one[15:9] == $past(status_display_code))
		else $error("status code wrong");

	din_mirror_a: assert property (
		ce [*3] |=> tech_status_word_two[4:0] == $past(gen_inputs, 3))
		else $error("general inputs not mirrored");

	relay_mirror_a: assert property (
		ce [*3] |=> tech_status_word_two[15:14] == $past(relay_outputs, 3))
		else $error("relay outputs not mirrored");

	safety_err_a: assert property (
		ce |=> tech_status_word_two[9:8] == $past(safety_input_errors))
		else $error("safety input errors wrong");

	freq_err_a: assert property (
		ce |=> tech_status_word_two[13:12] ==
		$past(safety_freq_input_errors))
		else $error("frequency errors wrong");

	load_max_a: assert property (
		ce |=> tech_status_word_three[6:0] >= $past(ctrl_load_percent) &&
		tech_status_word_three[6:0] >= $past(motor_load_percent))
		else $error("system load not the larger value");

	pos_invalid_a: assert property (
		ce && !position_valid |=> tech_status_word_three[14:8] == 7'h7F)
		else $error("invalid position not 127");

	reserved_zero_a: assert property (
		!tech_status_word_two[7] && !tech_status_word_three[7] &&
		!tech_status_word_three[15])
		else $error("reserved bit set");

	read_release_a: assert property (
		rd_req_s ##1 rd_hold_s |-> !avs_waitrequest)
		else $error("read not released after one wait cycle");

	event_sticky_a: assert property (
		ce && ev_rise[0] |=> st_reg.sts[0] [*2])
		else $error("event bit not held");

	irq_level_a: assert property (
		ce && !avs_write && (ev_rise & st_reg.mask) != DSW_EV_RST
		|=> irq)
		else $error("unmasked event did not raise the interrupt");

	safety_inputs_mirror_a: assert property (
		ce [*3] |=> tech_status_word_two[6:5] ==
		$past(safety_inputs, 3))
		else $error("safety inputs not mirrored");

	freq_mirror_a: assert property (
		ce [*3] |=> tech_status_word_two[11:10] ==
		$past(safety_freq_inputs, 3))
		else $error("frequency inputs not mirrored");

	load_ctrl_a: assert property (
		ce && ctrl_load_percent >= motor_load_percent
		|=> tech_status_word_three[6:0] == $past(ctrl_load_percent))
		else $error("system load not the controller load");

	load_motor_a: assert property (
		ce && motor_load_percent > ctrl_load_percent
		|=> tech_status_word_three[6:0] == $past(motor_load_percent))
		else $error("system load not the motor load");

	pos_valid_a: assert property (
		ce && position_valid
		|=> tech_status_word_three[14:8] == $past(door_position_percent))
		else $error("door position not reported");

	force_low_a: assert property (
		ce && force_valid && open_force_deviation <= DSW_DEV_M75
		|=> tech_status_word_one[5:3] == 3'h1)
		else $error("force band wrong for large negative deviation");

	force_mid_a: assert property (
		ce && force_valid && open_force_deviation > DSW_DEV_M25 &&
		open_force_deviation < DSW_DEV_P25
		|=> tech_status_word_one[5:3] == 3'h4)
		else $error("force band wrong near zero deviation");

	low_field_a: assert property (
		tech_status_word_one[2:0] == 3'h0)
		else $error("unused low field of word one set");

	unmapped_read_a: assert property (
		ce && avs_read && !st_reg.ack && avs_address > DSW_OFS_MASK
		|=> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	mask_write_a: assert property (
		mask_wr_s |=> st_reg.mask == $past(wdata_lo))
		else $error("mask write not taken");

	status_clear_a: assert property (
		stat_rd_s
		|=> (st_reg.sts & $past(st_reg.rd_snap)) == DSW_EV_RST)
		else $error("reported status bits not cleared");
endmodule

// *** core/dsw_pkg.sv ***
// Overview of operation
// - Opening force deviation band occupies bits 3 to 5 of word one.
// - Band 0 means unavailable; 1 to 7 ascend from -75% to +75%.
// - Word one bit 6 set while opening obstruction is recognized.
// - Word one bit 7 set while closing obstruction is recognized.
// - Word one bit 8 high while an obstruction response is active.
// - Seven-bit status display code in word one bits 9 to 15.
// - General digital inputs 0 to 4 mirrored in word two bits 0 to 4.
// - Safety digital inputs 0 and 1 in word two bits 5 and 6.
// - Safety digital input errors in word two bits 8 and 9.
// - Safety frequency inputs 0 and 1 in word two bits 10 and 11.
// - Safety frequency input errors in word two bits 12 and 13.
// - Relay outputs 0 and 1 mirrored in word two bits 14 and 15.
// - Seven-bit system load percentage in word three bits 0 to 6.
// - System load is the larger of controller and motor load.
// - Door position in word three bits 8 to 14; 127 when invalid.
package dsw_pkg;
	localparam logic [4:0] DSW_OFS_WORD1 = 5'h00;
	localparam logic [4:0] DSW_OFS_WORD2 = 5'h04;
	localparam logic [4:0] DSW_OFS_WORD3 = 5'h08;
	localparam logic [4:0] DSW_OFS_STAT  = 5'h0C;
	localparam logic [4:0] DSW_OFS_MASK  = 5'h10;

	localparam int DSW_W1_FORCE  = 3;
	localparam int DSW_W1_OBST   = 6;
	localparam int DSW_W1_RESP   = 8;
	localparam int DSW_W1_CODE   = 9;
	localparam int DSW_W2_DIN    = 0;
	localparam int DSW_W2_SAFETY_INPUTS   = 5;
	localparam int DSW_W2_SDERR  = 8;
	localparam int DSW_W2_SAFETY_FREQ_INPUTS   = 10;
	localparam int DSW_W2_SFERR  = 12;
	localparam int DSW_W2_RELAY  = 14;
	localparam int DSW_W3_LOAD   = 0;
	localparam int DSW_W3_POS    = 8;

	localparam logic [15:0] DSW_WORD_RST  = 16'h0000;
	localparam logic [4:0]  DSW_EV_RST    = 5'h00;
	localparam logic [6:0]  DSW_POS_NONE  = 7'h7F;
	localparam int          DSW_EV_N      = 5;

	localparam logic signed [7:0] DSW_DEV_M75 = -8'sd75;
	localparam logic signed [7:0] DSW_DEV_M50 = -8'sd50;
	localparam logic signed [7:0] DSW_DEV_M25 = -8'sd25;
	localparam logic signed [7:0] DSW_DEV_P25 = 8'sd25;
	localparam logic signed [7:0] DSW_DEV_P50 = 8'sd50;
	localparam logic signed [7:0] DSW_DEV_P75 = 8'sd75;
endpackage

// *** core/dsw_sync.sv ***
`timescale 1ns/10ps
module dsw_sync
	import dsw_pkg::*;
#(
	parameter int W = 11
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} dsw_sync_state_t;

	dsw_sync_state_t st_reg;
	dsw_sync_state_t st_next;

	// First stage feeds only the second stage
	always_comb begin
		st_next = st_reg;
		if (ce) begin
			st_next.s1 = d;
			st_next.s2 = st_reg.s1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign q = st_reg.s2;
endmodule

// *** core/dsw_band_enc.sv ***
`timescale 1ns/10ps
module dsw_band_enc
	import dsw_pkg::*;
(
	input  wire logic              valid,
	input  wire logic signed [7:0] dev_pct,
	output logic             [2:0] code
);
	always_comb begin
		if (!valid)
			code = 3'h0;
		else if (dev_pct <= DSW_DEV_M75)
			code = 3'h1;
		else if (dev_pct <= DSW_DEV_M50)
			code = 3'h2;
		else if (dev_pct <= DSW_DEV_M25)
			code = 3'h3;
		else if (dev_pct < DSW_DEV_P25)
			code = 3'h4;
		else if (dev_pct < DSW_DEV_P50)
			code = 3'h5;
		else if (dev_pct < DSW_DEV_P75)
			code = 3'h6;
		else
			code = 3'h7;
	end
endmodule

// *** dv/dsw_ctrl_model.sv ***
`timescale 1ns/10ps
module dsw_ctrl_model
	import dsw_pkg::*;
#(
	parameter int CYCLE = 16
) (
	sys_clk,
	word_one,
	word_two,
	word_three,
	snap_one,
	snap_two,
	snap_three
);
	input  wire logic        sys_clk;
	input  wire logic [15:0] word_one;
	input  wire logic [15:0] word_two;
	input  wire logic [15:0] word_three;
	output logic      [15:0] snap_one;
	output logic      [15:0] snap_two;
	output logic      [15:0] snap_three;

	int cnt = 0;

	// Cyclic process data: the controller only sees a periodic snapshot
	always @(posedge sys_clk) begin
		cnt <= (cnt == CYCLE - 1) ? 0 : cnt + 1;
		if (cnt == 0) begin
			snap_one <= word_one;
			snap_two <= word_two;
			snap_three <= word_three;
		end
	end
endmodule

// *** dv/door_status_word_packer_tb.sv ***
`timescale 1ns/10ps
module door_status_word_packer_tb;
	import dsw_pkg::*;
	typedef struct {
		logic fv; logic [7:0] dev; logic [2:0] band;
		logic [6:0] cl, ml, load; logic pv; logic [6:0] pos, epos;
	} dsw_row_t;
	dsw_row_t rows [8] = '{
		'{1'h0, 8'hA6, 3'h0, 7'h10, 7'h20, 7'h20, 1'h1, 7'h00, 7'h00},
		'{1'h1, 8'hB5, 3'h1, 7'h7F, 7'h00, 7'h7F, 1'h1, 7'h64, 7'h64},
		'{1'h1, 8'hCE, 3'h2, 7'h00, 7'h7F, 7'h7F, 1'h0, 7'h32, 7'h7F},
		'{1'h1, 8'hE7, 3'h3, 7'h40, 7'h3F, 7'h40, 1'h1, 7'h01, 7'h01},
		'{1'h1, 8'h18, 3'h4, 7'h05, 7'h05, 7'h05, 1'h1, 7'h63, 7'h63},
		'{1'h1, 8'h19, 3'h5, 7'h00, 7'h00, 7'h00, 1'h0, 7'h00, 7'h7F},
		'{1'h1, 8'h4A, 3'h6, 7'h12, 7'h34, 7'h34, 1'h1, 7'h7E, 7'h7E},
		'{1'h1, 8'h4B, 3'h7, 7'h55, 7'h2A, 7'h55, 1'h1, 7'h7F, 7'h7F}};
	logic sys_clk = 1'h0, nrst = 1'h0, ce = 1'h1, fv = 1'h0, resp = 1'h0;
	logic signed [7:0] dev = 8'h00;
	logic [1:0] obst = 2'h0;
	logic [6:0] code = 7'h00, cl = 7'h00, ml = 7'h00, pos = 7'h00;
	logic [14:0] pat = 15'h0000;
	logic pv = 1'h0, rd = 1'h0, wr = 1'h0;
	logic [4:0] adr = 5'h00;
	logic [3:0] be = 4'hF;
	logic [31:0] wd = 32'h0, rdata, d;
	logic waitreq, irq;
	logic [15:0] w1, w2, w3, s1, s2, s3, e [3];
	int n_fail = 0, cmp_count = 0, cyc = 0;

	dsw_packer dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
		.force_valid(fv), .open_force_deviation(dev),
		.obstruction_flags(obst), .obstruction_response_active(resp),
		.status_display_code(code), .gen_inputs(pat[4:0]),
		.safety_inputs(pat[6:5]), .safety_input_errors(pat[8:7]),
		.safety_freq_inputs(pat[10:9]), .safety_freq_input_errors(pat[12:11]),
		.relay_outputs(pat[14:13]), .ctrl_load_percent(cl),
		.motor_load_percent(ml), .position_valid(pv),
		.door_position_percent(pos), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
		.avs_readdata(rdata), .avs_waitrequest(waitreq), .irq(irq),
		.tech_status_word_one(w1), .tech_status_word_two(w2),
		.tech_status_word_three(w3));
	dsw_ctrl_model #(.CYCLE(16)) ctrl (.sys_clk(sys_clk), .word_one(w1),
		.word_two(w2), .word_three(w3), .snap_one(s1), .snap_two(s2),
		.snap_three(s3));

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic chk(input string nm, input logic [31:0] ex, got);
		cmp_count++;
		if (got !== ex) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// Hold the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] v, output logic [31:0] q);
		int n;
		@(posedge sys_clk);
		adr <= a;
		wd <= v;
		rd <= ~w;
		wr <= w;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (waitreq !== 1'h0 && n < 50);
		if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
		q = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
	endtask

	task automatic give_verdict();
		$display("Compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_fail++;
			give_verdict();
		end
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		chk("reset word one", 32'h0, {16'h0, w1});
		chk("reset irq", 32'h0, {31'h0, irq});
		nrst <= 1'h1;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			fv <= rows[i].fv;
			dev <= rows[i].dev;
			cl <= rows[i].cl;
			ml <= rows[i].ml;
			pv <= rows[i].pv;
			pos <= rows[i].pos;
			obst <= i[1:0];
			resp <= i[2];
			code <= {i[2:0], ~i[2:0], i[0]};
			pat <= {5{i[2:0]}} ^ 15'h2AAA;
			repeat (5) @(posedge sys_clk);
			e[0] = {code, resp, obst, rows[i].band, 3'h0};
			e[1] = {pat[14:7], 1'h0, pat[6:0]};
			e[2] = {1'h0, rows[i].epos, 1'h0, rows[i].load};
			chk("word one", {24'h0, e[0][7:0]}, {24'h0, w1[7:3], 3'h0});
			chk("word one hi", {24'h0, e[0][15:8]}, {24'h0, w1[15:8]});
			chk("word two", {24'h0, e[1][7:0]}, {24'h0, w2[7:0]});
			chk("word two hi", {24'h0, e[1][15:8]}, {24'h0, w2[15:8]});
			chk("word three", {16'h0, e[2]}, {16'h0, w3});
			for (int k = 0; k < 3; k++) begin
				bus(1'h0, 5'(k * 4), 32'h0, d);
				chk("bus word", {16'h0, e[k]}, d);
			end
		end
		obst <= 2'h0;
		resp <= 1'h0;
		pat <= 15'h0000;
		bus(1'h0, DSW_OFS_STAT, 32'h0, d);
		bus(1'h1, DSW_OFS_MASK, 32'h1F, d);
		bus(1'h1, DSW_OFS_WORD3, 32'hFFFF, d);
		chk("ro word", {16'h0, e[2]}, {16'h0, w3});
		bus(1'h0, 5'h14, 32'h0, d);
		chk("unmapped", 32'h0, d);
		bus(1'h0, DSW_OFS_STAT, 32'h0, d);
		obst <= 2'h1;
		repeat (3) @(posedge sys_clk);
		chk("irq raised", 32'h1, {31'h0, irq});
		bus(1'h0, DSW_OFS_STAT, 32'h0, d);
		chk("status", 32'h1, d);
		repeat (2) @(posedge sys_clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		bus(1'h1, DSW_OFS_MASK, 32'h1B, d);
		resp <= 1'h1;
		repeat (3) @(posedge sys_clk);
		chk("irq masked", 32'h0, {31'h0, irq});
		bus(1'h0, DSW_OFS_STAT, 32'h0, d);
		chk("status masked", 32'h4, d);
		bus(1'h0, DSW_OFS_MASK, 32'h0, d);
		chk("mask", 32'h1B, d);
		be <= 4'h0;
		bus(1'h1, DSW_OFS_MASK, 32'h0, d);
		be <= 4'hF;
		bus(1'h0, DSW_OFS_MASK, 32'h0, d);
		chk("mask lane", 32'h1B, d);
		repeat (20) @(posedge sys_clk);
		e[0] = {code, 1'h1, 2'h1, rows[7].band, 3'h0};
		chk("snapshot one", {16'h0, e[0]}, {16'h0, s1});
		chk("snapshot two", 32'h0, {16'h0, s2});
		chk("snapshot three", {16'h0, e[2]}, {16'h0, s3});
		// Enable low must freeze the words
		ce <= 1'h0;
		obst <= 2'h2;
		repeat (4) @(posedge sys_clk);
		chk("frozen word", {16'h0, e[0]}, {16'h0, w1});
		ce <= 1'h1;
		repeat (2) @(posedge sys_clk);
		e[0] = {code, 1'h1, 2'h2, rows[7].band, 3'h0};
		chk("thawed word", {16'h0, e[0]}, {16'h0, w1});
		// Reset in mid-run
		obst <= 2'h0;
		resp <= 1'h0;
		nrst <= 1'h0;
		@(posedge sys_clk);
		chk("mid reset word", 32'h0, {16'h0, w1});
		chk("mid reset irq", 32'h0, {31'h0, irq});
		nrst <= 1'h1;
		repeat (4) @(posedge sys_clk);
		bus(1'h0, DSW_OFS_MASK, 32'h0, d);
		chk("mask after reset", 32'h0, d);
		bus(1'h0, DSW_OFS_STAT, 32'h0, d);
		chk("status after reset", 32'h0, d);
		give_verdict();
	end
endmodule
